// ### exec_core_pkg.sv
package exec_core_pkg;
    // Register byte offsets on the APB window
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_IPTR = 8'h0c;
    localparam logic [7:0] OFF_STACK = 8'h10;
    localparam logic [7:0] OFF_FADDR = 8'h14;
    localparam logic [7:0] OFF_FDATA = 8'h18;
    localparam logic [7:0] OFF_WDOG = 8'h1c;

    // Instruction word fields
    localparam int OP_LSB = 0;
    localparam int DEST_BIT = 2;
    localparam int WAKE_BIT = 3;
    localparam int FADDR_LSB = 8;
    localparam int FADDR_W = 7;
    localparam int LIT_LSB = 16;

    // Status word fields
    localparam int ST_CARRY = 0;
    localparam int ST_SLEEP_FLAG = 3;
    localparam int ST_EXPIRY_FLAG = 4;
    localparam int ST_BUSY = 8;
    localparam int ST_HALT = 9;
    localparam int ST_SP_LSB = 16;

    // Widths
    localparam int IPTR_W = 13;
    localparam int CNT_W = 4;

    // Values after reset
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [12:0] RST_IPTR = 13'h0000;
    localparam logic RST_CARRY = 1'b0;
    localparam logic RST_SLEEP_FLAG = 1'b1;
    localparam logic RST_EXPIRY_FLAG = 1'b1;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [6:0] RST_FADDR = 7'h00;

    // Timing: one instruction cycle spans several core clocks
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 40;
    localparam int CLKS_PER_ICYC = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXIT_ICYC = 2;
    localparam int ROTATE_ICYC = 1;
    localparam int SLEEP_ICYC = 1;

    typedef enum logic [1:0] {
        OP_EXIT_CONST = 2'b00,
        OP_EXIT_PLAIN = 2'b01,
        OP_ROTATE = 2'b10,
        OP_SLEEP = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_EXEC = 2'b01,
        S_HALT = 2'b10
    } state_t;
endpackage

// ### exec_core.sv
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - Exit-with-constant loads the 8-bit accumulator with its literal byte, any value from 0 to 255.
// - Exit-with-constant pops the return stack and loads the popped address into the instruction pointer.
// - Exit-with-constant is one program word and takes two instruction cycles.
// - Plain exit pops the return stack into the instruction pointer and takes two instruction cycles.
// - Neither exit instruction touches any status flag, and the plain exit has no operand.
// - Rotate-left shifts the register left, old carry into bit 0 and old bit 7 into carry.
// - Rotate-left with target bit 0 writes the accumulator and keeps the source; with 1 it writes the source.
// - Sleep clears the sleep-entered flag and sets the watchdog-expiry flag.
// - Sleep clears the watchdog counter and its prescaler.
// - After sleep the core halts with its clock stopped and runs no further instruction until a wake write to the instruction register.
module exec_core #(
    parameter int STACK_DEPTH = 8,
    parameter int FILE_WORDS = 128,
    parameter int PRE_W = 8
) (
    input wire logic clk_i, // Core clock, 100 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction, high for write
    input wire logic [7:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error
    output logic busy_o, // Instruction in flight
    output logic halted_o // Core halted by sleep
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    exec_core_pkg::state_t state_ff;
    exec_core_pkg::state_t nxt_state;
    logic busy_ff;
    logic halted_ff;
    exec_core_pkg::op_t op_ff;
    logic dest_ff;
    logic [6:0] faddr_ff;
    logic [7:0] lit_ff;
    logic [exec_core_pkg::CNT_W-1:0] cnt_ff;
    logic [7:0] acc_ff;
    logic carry_ff;
    logic sleep_flag_ff;
    logic expiry_flag_ff;
    logic [12:0] iptr_ff;
    logic [SP_W-1:0] sp_ff;
    logic [SP_W-1:0] sp_dec;
    logic [12:0] stack_mem [STACK_DEPTH];
    logic [7:0] file_mem [FILE_WORDS];
    logic [6:0] fsel_ff;
    logic [7:0] wdog_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [7:0] rot_src;
    logic [7:0] rot_res;
    logic access;
    logic wr_fire;
    logic issue;
    logic done;

    // Clocks an instruction occupies, less one, as the down-counter load
    function automatic logic [exec_core_pkg::CNT_W-1:0] exec_load(input exec_core_pkg::op_t op);
        int icyc;
        icyc = exec_core_pkg::EXIT_ICYC;
        if (op == exec_core_pkg::OP_ROTATE) begin
            icyc = exec_core_pkg::ROTATE_ICYC;
        end else if (op == exec_core_pkg::OP_SLEEP) begin
            icyc = exec_core_pkg::SLEEP_ICYC;
        end
        return exec_core_pkg::CNT_W'(icyc * exec_core_pkg::CLKS_PER_ICYC - 1);
    endfunction

    // Address decode with access policy; used by the error path only, the read mux decodes on its own
    function automatic logic reg_ok(input logic [7:0] addr, input logic wr, input exec_core_pkg::state_t st,
                                    input logic wake);
        logic ok;
        ok = 1'b0;
        unique case (addr)
            exec_core_pkg::OFF_INSTR: ok = !wr || st == exec_core_pkg::S_IDLE || (st == exec_core_pkg::S_HALT && wake);
            exec_core_pkg::OFF_ACC, exec_core_pkg::OFF_STATUS, exec_core_pkg::OFF_IPTR, exec_core_pkg::OFF_STACK,
            exec_core_pkg::OFF_FADDR, exec_core_pkg::OFF_FDATA: ok = !wr || st == exec_core_pkg::S_IDLE;
            exec_core_pkg::OFF_WDOG: ok = !wr;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    assign access = psel_i && penable_i && !pready_ff;
    // Writes land only at the edge that completes the transfer, and only if not refused
    assign wr_fire = psel_i && penable_i && pwrite_i && pready_ff && !pslverr_ff;
    assign issue = wr_fire && paddr_i == exec_core_pkg::OFF_INSTR && state_ff == exec_core_pkg::S_IDLE;
    assign done = state_ff == exec_core_pkg::S_EXEC && cnt_ff == '0;
    assign sp_dec = sp_ff - SP_W'(1);
    assign rot_src = file_mem[faddr_ff];
    assign rot_res = {rot_src[6:0], carry_ff};

    // One wait state on every access; keeps decode off the combinational path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= access;
            pslverr_ff <= access && !reg_ok(paddr_i, pwrite_i, state_ff, pwdata_i[exec_core_pkg::WAKE_BIT]);
        end
    end

    // Read mux, captured one cycle before the answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (access && !pwrite_i) begin
            prdata_ff <= 32'h0000_0000;
            unique case (paddr_i)
                exec_core_pkg::OFF_INSTR: prdata_ff <= {8'h00, lit_ff, 1'b0, faddr_ff, 5'h00, dest_ff, op_ff};
                exec_core_pkg::OFF_ACC: prdata_ff <= {24'h000000, acc_ff};
                exec_core_pkg::OFF_STATUS: begin
                    prdata_ff[exec_core_pkg::ST_CARRY] <= carry_ff;
                    prdata_ff[exec_core_pkg::ST_SLEEP_FLAG] <= sleep_flag_ff;
                    prdata_ff[exec_core_pkg::ST_EXPIRY_FLAG] <= expiry_flag_ff;
                    prdata_ff[exec_core_pkg::ST_BUSY] <= busy_ff;
                    prdata_ff[exec_core_pkg::ST_HALT] <= halted_ff;
                    prdata_ff[exec_core_pkg::ST_SP_LSB +: SP_W] <= sp_ff;
                end
                exec_core_pkg::OFF_IPTR: prdata_ff <= {19'h00000, iptr_ff};
                exec_core_pkg::OFF_STACK: prdata_ff <= {19'h00000, stack_mem[sp_dec]};
                exec_core_pkg::OFF_FADDR: prdata_ff <= {25'h0000000, fsel_ff};
                exec_core_pkg::OFF_FDATA: prdata_ff <= {24'h000000, file_mem[fsel_ff]};
                exec_core_pkg::OFF_WDOG: prdata_ff <= {24'h000000, wdog_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Sequencer: idle, executing, halted
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            exec_core_pkg::S_IDLE: if (issue) nxt_state = exec_core_pkg::S_EXEC;
            exec_core_pkg::S_EXEC: begin
                if (done) begin
                    // Sleep stops the instruction clock; only a wake write restarts it
                    nxt_state = op_ff == exec_core_pkg::OP_SLEEP ? exec_core_pkg::S_HALT : exec_core_pkg::S_IDLE;
                end
            end
            exec_core_pkg::S_HALT: if (wr_fire && paddr_i == exec_core_pkg::OFF_INSTR) nxt_state = exec_core_pkg::S_IDLE;
            default: nxt_state = exec_core_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= exec_core_pkg::S_IDLE;
            busy_ff <= 1'b0;
            halted_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_state == exec_core_pkg::S_EXEC;
            halted_ff <= nxt_state == exec_core_pkg::S_HALT;
        end
    end

    // Latch the issued instruction; the exit forms ignore unused fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_ff <= exec_core_pkg::OP_EXIT_PLAIN;
            dest_ff <= 1'b0;
            faddr_ff <= exec_core_pkg::RST_FADDR;
            lit_ff <= 8'h00;
            cnt_ff <= '0;
        end else if (issue) begin
            op_ff <= exec_core_pkg::op_t'(pwdata_i[exec_core_pkg::OP_LSB +: 2]);
            dest_ff <= pwdata_i[exec_core_pkg::DEST_BIT];
            faddr_ff <= pwdata_i[exec_core_pkg::FADDR_LSB +: exec_core_pkg::FADDR_W];
            lit_ff <= pwdata_i[exec_core_pkg::LIT_LSB +: 8];
            cnt_ff <= exec_load(exec_core_pkg::op_t'(pwdata_i[exec_core_pkg::OP_LSB +: 2]));
        end else if (state_ff == exec_core_pkg::S_EXEC && cnt_ff != '0) begin
            cnt_ff <= cnt_ff - exec_core_pkg::CNT_W'(1);
        end
    end

    // Accumulator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= exec_core_pkg::RST_ACC;
        end else if (done && op_ff == exec_core_pkg::OP_EXIT_CONST) begin
            acc_ff <= lit_ff;
        end else if (done && op_ff == exec_core_pkg::OP_ROTATE && !dest_ff) begin
            acc_ff <= rot_res;
        end else if (wr_fire && paddr_i == exec_core_pkg::OFF_ACC) begin
            acc_ff <= pwdata_i[7:0];
        end
    end

    // Carry: only the rotate changes it among the instructions here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_ff <= exec_core_pkg::RST_CARRY;
        end else if (done && op_ff == exec_core_pkg::OP_ROTATE) begin
            carry_ff <= rot_src[7];
        end else if (wr_fire && paddr_i == exec_core_pkg::OFF_STATUS) begin
            carry_ff <= pwdata_i[exec_core_pkg::ST_CARRY];
        end
    end

    // Power flags are read-only to software; sleep wins over a same-cycle timeout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_flag_ff <= exec_core_pkg::RST_SLEEP_FLAG;
            expiry_flag_ff <= exec_core_pkg::RST_EXPIRY_FLAG;
        end else if (done && op_ff == exec_core_pkg::OP_SLEEP) begin
            sleep_flag_ff <= 1'b0;
            expiry_flag_ff <= 1'b1;
        end else if (wdog_ff == 8'hff && &pre_ff) begin
            expiry_flag_ff <= 1'b0;
        end
    end

    // Instruction pointer and return stack; the stack wraps rather than faulting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iptr_ff <= exec_core_pkg::RST_IPTR;
            sp_ff <= '0;
        end else if (done && (op_ff == exec_core_pkg::OP_EXIT_CONST || op_ff == exec_core_pkg::OP_EXIT_PLAIN)) begin
            iptr_ff <= stack_mem[sp_dec];
            sp_ff <= sp_dec;
        end else if (done) begin
            iptr_ff <= iptr_ff + 13'h0001;
        end else if (wr_fire && paddr_i == exec_core_pkg::OFF_IPTR) begin
            iptr_ff <= pwdata_i[12:0];
        end else if (wr_fire && paddr_i == exec_core_pkg::OFF_STACK) begin
            sp_ff <= sp_ff + SP_W'(1);
        end
    end

    // Stack storage, filled by software pushes
    always_ff @(posedge clk_i) begin
        if (wr_fire && paddr_i == exec_core_pkg::OFF_STACK) begin
            stack_mem[sp_ff] <= pwdata_i[12:0];
        end
    end

    // File registers: software window plus rotate write-back
    always_ff @(posedge clk_i) begin
        if (done && op_ff == exec_core_pkg::OP_ROTATE && dest_ff) begin
            file_mem[faddr_ff] <= rot_res;
        end else if (wr_fire && paddr_i == exec_core_pkg::OFF_FDATA) begin
            file_mem[fsel_ff] <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fsel_ff <= exec_core_pkg::RST_FADDR;
        end else if (wr_fire && paddr_i == exec_core_pkg::OFF_FADDR) begin
            fsel_ff <= pwdata_i[6:0];
        end
    end

    // Watchdog and prescaler; frozen while halted since the clock is stopped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdog_ff <= exec_core_pkg::RST_WDOG;
            pre_ff <= '0;
        end else if (done && op_ff == exec_core_pkg::OP_SLEEP) begin
            wdog_ff <= 8'h00;
            pre_ff <= '0;
        end else if (state_ff != exec_core_pkg::S_HALT) begin
            pre_ff <= pre_ff + PRE_W'(1);
            if (&pre_ff) begin
                wdog_ff <= wdog_ff + 8'h01;
            end
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign busy_o = busy_ff;
    assign halted_o = halted_ff;

    // Clocks spent in execution, for the timing checks
    logic [7:0] len_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff != exec_core_pkg::S_EXEC) begin
            len_ff <= 8'h00;
        end else begin
            len_ff <= len_ff + 8'h01;
        end
    end

    exit_const_acc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff == exec_core_pkg::OP_EXIT_CONST |=> acc_ff == $past(lit_ff))
        else $error("accumulator did not take the literal");

    exit_pop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff != exec_core_pkg::OP_ROTATE && op_ff != exec_core_pkg::OP_SLEEP
        |=> iptr_ff == $past(stack_mem[sp_dec]) && sp_ff == $past(sp_dec))
        else $error("exit did not pop the stack into the pointer");

    exit_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff != exec_core_pkg::OP_ROTATE && op_ff != exec_core_pkg::OP_SLEEP
        |-> len_ff == 8'(exec_core_pkg::EXIT_ICYC * exec_core_pkg::CLKS_PER_ICYC - 1))
        else $error("exit did not take two instruction cycles");

    plain_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        issue && pwdata_i[1:0] == 2'b01 |=> busy_o [*8] ##1 !busy_o)
        else $error("plain exit busy window wrong");

    exit_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff != exec_core_pkg::OP_ROTATE && op_ff != exec_core_pkg::OP_SLEEP
        |=> $stable(carry_ff) && $stable(sleep_flag_ff))
        else $error("exit changed a status flag");

    rotate_acc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff == exec_core_pkg::OP_ROTATE && !dest_ff
        |=> acc_ff == {$past(rot_src[6:0]), $past(carry_ff)} && carry_ff == $past(rot_src[7])
            && file_mem[faddr_ff] == $past(rot_src))
        else $error("rotate into accumulator wrong");

    rotate_file_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff == exec_core_pkg::OP_ROTATE && dest_ff
        |=> file_mem[faddr_ff] == $past(rot_res) && $stable(acc_ff))
        else $error("rotate write-back wrong");

    rotate_short_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff == exec_core_pkg::OP_ROTATE
        |-> len_ff == 8'(exec_core_pkg::CLKS_PER_ICYC - 1) ##1 $stable(sleep_flag_ff))
        else $error("rotate length or flags wrong");

    sleep_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff == exec_core_pkg::OP_SLEEP |=> !sleep_flag_ff && expiry_flag_ff && halted_o)
        else $error("sleep flags wrong");

    sleep_wdog_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && op_ff == exec_core_pkg::OP_SLEEP |=> wdog_ff == 8'h00 && pre_ff == '0)
        else $error("watchdog not cleared by sleep");

    halt_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
        halted_o && !wr_fire |=> $stable(iptr_ff) && !busy_o && $stable(wdog_ff))
        else $error("core ran while halted");
endmodule

// ### test_return_rotate_sleep_ops.sv
`timescale 1ns/1ps
module test_return_rotate_sleep_ops;
    localparam int PRE_W = 2;
    localparam int CYC = exec_core_pkg::CLKS_PER_ICYC;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic busy_o;
    logic halted_o;
    int miscompares = 0;
    int n_compared = 0;
    integer seed = 38;
    int cyc = 0;
    logic [64:0] apb_q[$];
    logic [8:0] busy_q[$];
    logic [64:0] ae;
    logic [8:0] be;
    logic [7:0] bcnt = 8'h00;

    // Free-running core clock, 10 ns period
    always #5 clk_i = ~clk_i;

    exec_core #(.STACK_DEPTH(8), .FILE_WORDS(128), .PRE_W(PRE_W)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .busy_o(busy_o), .halted_o(halted_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic hang();
        miscompares++;
        tally_and_finish();
    endtask

    // One APB transfer; expectation is queued before the request goes out
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       input logic err, input logic [31:0] mask, input logic [31:0] exp);
        int n;
        apb_q.push_back({err, mask, exp});
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= data;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) hang();
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, err, 32'h00000000, 32'h00000000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000, 1'b0, m, e);
    endtask

    // Issue an instruction; busy length and halt state are noted for the watcher
    task automatic issue(input logic [31:0] w, input logic [7:0] len, input logic halt);
        busy_q.push_back({halt, len});
        wr(exec_core_pkg::OFF_INSTR, w, 1'b0);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy_o !== 1'b0 && n < 50);
        if (n >= 50) hang();
    endtask

    function automatic logic [31:0] instr(input logic [1:0] op, input logic dst, input logic wake,
                                          input logic [6:0] fa, input logic [7:0] lit);
        return {8'h00, lit, 1'b0, fa, 4'h0, wake, dst, op};
    endfunction

    // Watcher for APB answers: oldest note against each completed transfer
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            ae = apb_q.pop_front();
            check({31'h0, pslverr_o}, {31'h0, ae[64]});
            if (!ae[64] && ae[63:32] != 32'h0) check(prdata_o & ae[63:32], ae[31:0]);
        end
    end

    // Watcher for instruction length; halt must appear as busy drops
    always @(posedge clk_i) begin
        cyc <= rst_i ? 0 : cyc + 1;
        if (busy_o === 1'b1) begin
            bcnt <= bcnt + 8'h01;
        end else if (bcnt != 8'h00) begin
            be = busy_q.pop_front();
            check({23'h0, halted_o, bcnt}, {23'h0, be});
            bcnt <= 8'h00;
        end
    end

    initial begin
        logic [7:0] lit, acc0, v, r;
        logic [12:0] ent, ip0;
        logic [6:0] fa;
        logic c, d, op;
        int n;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // Values after reset, an unmapped place and the read-only counter
        rd(exec_core_pkg::OFF_STATUS, 32'h00070319, 32'h00000018);
        rd(exec_core_pkg::OFF_ACC, 32'h000000ff, 32'h00000000);
        rd(exec_core_pkg::OFF_IPTR, 32'h00001fff, 32'h00000000);
        apb(1'b0, 8'h20, 32'h0, 1'b1, 32'h0, 32'h0);
        wr(exec_core_pkg::OFF_WDOG, 32'h00000001, 1'b1);
        // Both exits, literal at both ends of its range, one refused back-to-back issue
        for (int i = 0; i < 6; i++) begin
            lit = (i == 0) ? 8'h00 : (i == 2) ? 8'hff : 8'($random(seed));
            op = i[0];
            ent = 13'($random(seed));
            c = 1'($random(seed));
            acc0 = 8'($random(seed));
            fa = 7'($random(seed));
            wr(exec_core_pkg::OFF_ACC, {24'h0, acc0}, 1'b0);
            wr(exec_core_pkg::OFF_STATUS, {31'h0, c}, 1'b0);
            wr(exec_core_pkg::OFF_STACK, {19'h0, ent}, 1'b0);
            issue(instr({1'b0, op}, 1'b0, 1'b0, fa, lit), 8'(exec_core_pkg::EXIT_ICYC * CYC), 1'b0);
            if (i == 2) wr(exec_core_pkg::OFF_INSTR, instr(2'b00, 1'b0, 1'b0, fa, ~lit), 1'b1);
            wait_idle();
            rd(exec_core_pkg::OFF_ACC, 32'h000000ff, {24'h0, op ? acc0 : lit});
            rd(exec_core_pkg::OFF_IPTR, 32'h00001fff, {19'h0, ent});
            rd(exec_core_pkg::OFF_STATUS, 32'h00070009, {28'h0, 3'b100, c});
        end
        // Rotate through carry, every target and carry value; first case is the worked example
        for (int i = 0; i < 8; i++) begin
            d = i[0];
            c = i[1];
            v = (i == 0) ? 8'he6 : 8'($random(seed));
            fa = 7'($random(seed));
            acc0 = 8'($random(seed));
            ip0 = 13'($random(seed));
            r = {v[6:0], c};
            wr(exec_core_pkg::OFF_FADDR, {25'h0, fa}, 1'b0);
            wr(exec_core_pkg::OFF_FDATA, {24'h0, v}, 1'b0);
            wr(exec_core_pkg::OFF_ACC, {24'h0, acc0}, 1'b0);
            wr(exec_core_pkg::OFF_STATUS, {31'h0, c}, 1'b0);
            wr(exec_core_pkg::OFF_IPTR, {19'h0, ip0}, 1'b0);
            issue(instr(2'b10, d, 1'b0, fa, 8'($random(seed))), 8'(exec_core_pkg::ROTATE_ICYC * CYC), 1'b0);
            wait_idle();
            rd(exec_core_pkg::OFF_ACC, 32'h000000ff, {24'h0, d ? acc0 : r});
            rd(exec_core_pkg::OFF_FDATA, 32'h000000ff, {24'h0, d ? r : v});
            rd(exec_core_pkg::OFF_STATUS, 32'h00000009, {28'h0, 3'b100, v[7]});
            rd(exec_core_pkg::OFF_IPTR, 32'h00001fff, {19'h0, ip0 + 13'h0001});
            acc0 = d ? acc0 : r;
        end
        // Let the watchdog wrap once so the expiry flag is low before sleeping
        n = 0;
        while (cyc < 1300 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) hang();
        rd(exec_core_pkg::OFF_STATUS, 32'h00000018, 32'h00000008);
        issue(instr(2'b11, 1'b0, 1'b0, 7'h00, 8'h00), 8'(exec_core_pkg::SLEEP_ICYC * CYC), 1'b1);
        wait_idle();
        rd(exec_core_pkg::OFF_STATUS, 32'h00000318, 32'h00000210);
        rd(exec_core_pkg::OFF_WDOG, 32'h000000ff, 32'h00000000);
        // Halted core refuses work and its counter stays frozen
        wr(exec_core_pkg::OFF_ACC, 32'h0000005a, 1'b1);
        wr(exec_core_pkg::OFF_INSTR, instr(2'b00, 1'b0, 1'b0, 7'h00, 8'h33), 1'b1);
        repeat (20) @(posedge clk_i);
        rd(exec_core_pkg::OFF_WDOG, 32'h000000ff, 32'h00000000);
        rd(exec_core_pkg::OFF_ACC, 32'h000000ff, {24'h0, acc0});
        // Software wake returns the core to idle
        wr(exec_core_pkg::OFF_INSTR, instr(2'b00, 1'b0, 1'b1, 7'h00, 8'h00), 1'b0);
        rd(exec_core_pkg::OFF_STATUS, 32'h00000300, 32'h00000000);
        @(posedge clk_i);
        check(32'(apb_q.size()), 32'h0);
        check(32'(busy_q.size()), 32'h0);
        tally_and_finish();
    end
endmodule
